/* logic/tsi2c_pkg.sv */
// ----------------------------------------------------------------------------
// Shared constants and types of the touch sensor serial target port.
// ----------------------------------------------------------------------------
package tsi2c_pkg;

  // Eight-bit target address with the direction bit cleared.
  localparam logic [7:0] TSI2C_DEV_ADDR = 8'hF0;
  // Direction bit value that selects a read.
  localparam logic TSI2C_DIR_READ = 1'b1;
  // Number of data bits in every byte on the wire.
  localparam logic [3:0] TSI2C_BYTE_BITS = 4'h8;
  // Reset value of the register index pointer.
  localparam logic [7:0] TSI2C_IDX_RST = 8'h00;

  // Longest pulse that the line filters must reject, in nanoseconds.
  localparam int TSI2C_SPIKE_NS = 50;
  // Period of the link sampling clock, in nanoseconds.
  localparam int TSI2C_LINK_PERIOD_NS = 6;
  // Samples a new level must stay stable before it is accepted (rounded up).
  localparam int TSI2C_FILT_CYC_INT =
    (TSI2C_SPIKE_NS + TSI2C_LINK_PERIOD_NS - 1) / TSI2C_LINK_PERIOD_NS;
  localparam logic [3:0] TSI2C_FILT_CYC = 4'(TSI2C_FILT_CYC_INT);

  // States of the bus engine.
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_RX_ACK, ST_WAIT_W, ST_WAIT_R, ST_TX, ST_TX_ACK, ST_IGNORE
  } tsi2c_state_type;

  // Meaning of the byte that is being received.
  typedef enum logic [1:0] {
    KIND_ADDR, KIND_INDEX, KIND_DATA
  } tsi2c_kind_type;

endpackage : tsi2c_pkg

/* logic/tsi2c_port.sv */
`timescale 1ns/1ps
// Summary of operation
// - SDA changes only while SCL is low.
// - SDA falling, SCL high: START, restart address.
// - SDA rising, SCL high: STOP, go idle.
// - Busy from START to STOP; repeated START identical.
// - Bytes are eight bits, count unlimited.
// - Every byte is followed by acknowledge slot.
// - Bits move most significant first.
// - Target may hold SCL low to stall.
// - Transmitter releases SDA in acknowledge slot.
// - Receiver holds SDA low to acknowledge.
// - Target leaves SDA high when it cannot serve.
// - Master reader refuses last byte; target releases SDA.
// - SCL is wired-AND among all participants.
// - Answer only the fixed target address.
// - Last bit of first byte selects direction.
// - Write: index byte, then data, index advances.
// - Read: returns consecutive registers from the index.

// ----------------------------------------------------------------------------
// Line conditioner: two-stage synchroniser followed by a stability filter.
// ----------------------------------------------------------------------------
module tsi2c_filt (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic line_in,
  output logic line_out
);
  import tsi2c_pkg::*;

  logic sync1_q; // First synchroniser stage, read only by the second.
  logic sync2_q; // Second synchroniser stage.
  logic [3:0] cnt_q; // Cycles the new level has been stable.

  // Synchronise the pin into the link domain; idle bus level is high.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= line_in;
      sync2_q <= sync1_q;
    end
  end

  // Accept a new level only after it has held for the spike time.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= 4'h0;
      line_out <= 1'b1;
    end else if (sync2_q == line_out) begin
      cnt_q <= 4'h0;
    end else if (cnt_q == TSI2C_FILT_CYC - 4'h1) begin
      cnt_q <= 4'h0;
      line_out <= sync2_q;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : tsi2c_filt

// ----------------------------------------------------------------------------
// Serial target port: bus engine on the link clock, register access on core.
// ----------------------------------------------------------------------------
module tsi2c_port (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic link_clk_in,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_we_out,
  output logic reg_re_out,
  input wire logic [7:0] reg_rdata_in,
  input wire logic reg_busy_in,
  output logic bus_busy_out
);
  import tsi2c_pkg::*;

  // --------------------------------------------------------------------------
  // Link domain declarations.
  // --------------------------------------------------------------------------
  logic scl_f; // Filtered clock line.
  logic sda_f; // Filtered data line.
  logic scl_p_q; // Filtered clock line one cycle earlier.
  logic sda_p_q; // Filtered data line one cycle earlier.
  logic scl_rise; // Clock line rose.
  logic scl_fall; // Clock line fell.
  logic start_evt; // START or repeated START seen.
  logic stop_evt; // STOP seen.
  tsi2c_state_type state_q; // Bus engine state.
  tsi2c_kind_type kind_q; // Meaning of the byte being received.
  logic [3:0] bit_cnt_q; // Bits moved in the current byte.
  logic [7:0] shift_q; // Byte shift register.
  logic rw_q; // Direction taken from the first byte.
  logic mack_q; // Master acknowledged the byte just sent.
  logic [7:0] idx_q; // Register index pointer.
  logic busy_q; // Bus held between START and STOP.
  logic scl_oe_q; // Holding SCL low.
  logic sda_oe_q; // Pulling SDA low.
  logic req_tgl_q; // Toggles once per register access request.
  logic req_we_q; // Request is a write.
  logic [7:0] req_addr_q; // Register address of the request.
  logic [7:0] req_wdata_q; // Write data of the request.
  logic ack_s1_q; // Answer toggle, first synchroniser stage.
  logic ack_s2_q; // Answer toggle, second synchroniser stage.
  logic ack_p_q; // Answer toggle, previous value.
  logic ack_evt; // Core finished the pending access.
  logic rbusy_s1_q; // Bank busy, first synchroniser stage.
  logic rbusy_s2_q; // Bank busy, second synchroniser stage.

  // --------------------------------------------------------------------------
  // Core domain declarations.
  // --------------------------------------------------------------------------
  logic req_s1_q; // Request toggle, first synchroniser stage.
  logic req_s2_q; // Request toggle, second synchroniser stage.
  logic req_p_q; // Request toggle, previous value.
  logic req_evt; // New request arrived.
  logic pend_q; // Access issued, answer due next cycle.
  logic ack_tgl_q; // Toggles once per finished access.
  logic [7:0] rdata_q; // Read data held for the link domain.
  logic bb_s1_q; // Bus busy, first synchroniser stage.
  logic bb_s2_q; // Bus busy, second synchroniser stage.

  // --------------------------------------------------------------------------
  // Line conditioning and bus condition detection.
  // --------------------------------------------------------------------------
  tsi2c_filt u_scl_filt (
    .clk_in(link_clk_in),
    .rstn_in(rstn_in),
    .line_in(scl_in),
    .line_out(scl_f)
  );

  tsi2c_filt u_sda_filt (
    .clk_in(link_clk_in),
    .rstn_in(rstn_in),
    .line_in(sda_in),
    .line_out(sda_f)
  );

  // Remember the filtered lines and synchronise core-side signals.
  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_p_q <= 1'b0;
      rbusy_s1_q <= 1'b0;
      rbusy_s2_q <= 1'b0;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      ack_p_q <= ack_s2_q;
      rbusy_s1_q <= reg_busy_in;
      rbusy_s2_q <= rbusy_s1_q;
    end
  end

  assign scl_rise = scl_f & ~scl_p_q;
  assign scl_fall = ~scl_f & scl_p_q;
  assign start_evt = scl_f & scl_p_q & ~sda_f & sda_p_q;
  assign stop_evt = scl_f & scl_p_q & sda_f & ~sda_p_q;
  assign ack_evt = ack_s2_q ^ ack_p_q;

  // Open-drain pins only ever pull low; the wire is pulled high outside.
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = scl_oe_q;
  assign sda_oe_out = sda_oe_q;

  // --------------------------------------------------------------------------
  // Bus engine.
  // --------------------------------------------------------------------------
  // Walks each byte and its acknowledge slot; SDA is changed on a fall, or in ST_WAIT_R while SCL is stretched low.
  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= ST_IDLE;
      kind_q <= KIND_ADDR;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
      idx_q <= TSI2C_IDX_RST;
      busy_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      req_tgl_q <= 1'b0;
      req_we_q <= 1'b0;
      req_addr_q <= 8'h00;
      req_wdata_q <= 8'h00;
    end else if (start_evt) begin
      // A repeated START restarts the address byte and keeps the bus busy.
      state_q <= ST_RX;
      kind_q <= KIND_ADDR;
      bit_cnt_q <= 4'h0;
      busy_q <= 1'b1;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (stop_evt) begin
      // STOP ends any transfer and frees the bus.
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        ST_RX: begin
          if (scl_rise && bit_cnt_q != TSI2C_BYTE_BITS) begin
            // Shift in on the rising edge, most significant bit first.
            shift_q <= {shift_q[6:0], sda_f};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == TSI2C_BYTE_BITS) begin
            // Byte complete: decide the acknowledge while SCL is low.
            bit_cnt_q <= 4'h0;
            if (kind_q == KIND_ADDR) begin
              if (shift_q[7:1] == TSI2C_DEV_ADDR[7:1] && !rbusy_s2_q) begin
                rw_q <= shift_q[0];
                sda_oe_q <= 1'b1;
                state_q <= ST_RX_ACK;
              end else begin
                state_q <= ST_IGNORE;
              end
            end else if (kind_q == KIND_INDEX) begin
              idx_q <= shift_q;
              kind_q <= KIND_DATA;
              sda_oe_q <= 1'b1;
              state_q <= ST_RX_ACK;
            end else if (rbusy_s2_q) begin
              state_q <= ST_IGNORE;
            end else begin
              // Stretch the clock until the bank has taken the byte.
              req_we_q <= 1'b1;
              req_addr_q <= idx_q;
              req_wdata_q <= shift_q;
              req_tgl_q <= ~req_tgl_q;
              scl_oe_q <= 1'b1;
              sda_oe_q <= 1'b1;
              state_q <= ST_WAIT_W;
            end
          end
        end
        ST_WAIT_W: begin
          if (ack_evt) begin
            idx_q <= idx_q + 8'h01;
            scl_oe_q <= 1'b0;
            state_q <= ST_RX_ACK;
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            // Release SDA after the acknowledge pulse.
            sda_oe_q <= 1'b0;
            if (kind_q == KIND_ADDR && rw_q == TSI2C_DIR_READ) begin
              req_we_q <= 1'b0;
              req_addr_q <= idx_q;
              req_tgl_q <= ~req_tgl_q;
              scl_oe_q <= 1'b1;
              state_q <= ST_WAIT_R;
            end else begin
              if (kind_q == KIND_ADDR) begin
                kind_q <= KIND_INDEX;
              end
              state_q <= ST_RX;
            end
          end
        end
        ST_WAIT_R: begin
          if (ack_evt) begin
            // Put the first bit out in the same cycle that SCL is released.
            sda_oe_q <= ~rdata_q[7];
            shift_q <= {rdata_q[6:0], 1'b0};
            bit_cnt_q <= 4'h1;
            idx_q <= idx_q + 8'h01;
            scl_oe_q <= 1'b0;
            state_q <= ST_TX;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_q == TSI2C_BYTE_BITS) begin
              sda_oe_q <= 1'b0;
              state_q <= ST_TX_ACK;
            end else begin
              sda_oe_q <= ~shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_f;
          end else if (scl_fall) begin
            if (mack_q) begin
              // Acknowledged: fetch the next register.
              req_we_q <= 1'b0;
              req_addr_q <= idx_q;
              req_tgl_q <= ~req_tgl_q;
              scl_oe_q <= 1'b1;
              state_q <= ST_WAIT_R;
            end else begin
              // Last byte refused: keep SDA free for STOP or restart.
              state_q <= ST_IGNORE;
            end
          end
        end
        ST_IDLE, ST_IGNORE: begin
          sda_oe_q <= 1'b0;
          scl_oe_q <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Core domain: register bank access.
  // --------------------------------------------------------------------------
  // Synchronise the request toggle and the bus busy level.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_p_q <= 1'b0;
      bb_s1_q <= 1'b0;
      bb_s2_q <= 1'b0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_p_q <= req_s2_q;
      bb_s1_q <= busy_q;
      bb_s2_q <= bb_s1_q;
    end
  end

  assign req_evt = req_s2_q ^ req_p_q;
  assign bus_busy_out = bb_s2_q;

  // Issue one strobe per request; link fields are stable while it crosses.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_addr_out <= 8'h00;
      reg_wdata_out <= 8'h00;
      reg_we_out <= 1'b0;
      reg_re_out <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      reg_we_out <= req_evt & req_we_q;
      reg_re_out <= req_evt & ~req_we_q;
      pend_q <= req_evt;
      if (req_evt) begin
        reg_addr_out <= req_addr_q;
        reg_wdata_out <= req_wdata_q;
      end
    end
  end

  // Capture read data in the strobe cycle and answer with a toggle.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= 8'h00;
      ack_tgl_q <= 1'b0;
    end else if (pend_q) begin
      if (reg_re_out) begin
        rdata_q <= reg_rdata_in;
      end
      ack_tgl_q <= ~ack_tgl_q;
    end
  end

endmodule : tsi2c_port

/* test/tsi2c_master_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Bus master model on open-drain lines.
// ----------------------------------------
module tsi2c_master (
  input wire logic clk_in,
  input wire logic scl_oe_in,
  input wire logic sda_oe_in,
  output logic scl_out,
  output logic sda_out
);
  logic scl_q = 1'b1; // Master SCL, high means released.
  logic sda_q = 1'b1; // Master SDA, high means released.
  // Pull-ups make each line the wired-AND of all drivers.
  assign scl_out = scl_q & ~scl_oe_in;
  assign sda_out = sda_q & ~sda_oe_in;
  // Waits a number of clocks.
  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
  endtask : w
  // Releases SCL, waits out a stretch by the target, then holds high.
  task automatic hi;
    int n;
    n = 0;
    scl_q <= 1'b1;
    w(1);
    while (!scl_out && n < 900) begin
      w(1);
      n++;
    end
    w(20);
  endtask : hi
  // One bit slot: data moves while SCL is low and is sampled late in the high phase.
  task automatic bt(input logic b, output logic s);
    w(5);
    sda_q <= b;
    w(20);
    hi();
    s = sda_out;
    scl_q <= 1'b0;
  endtask : bt
  // Makes a START or a repeated START.
  task automatic start;
    w(20);
    sda_q <= 1'b1;
    w(20);
    hi();
    sda_q <= 1'b0;
    w(20);
    scl_q <= 1'b0;
  endtask : start
  // Makes a STOP and leaves both lines released.
  task automatic stop;
    w(20);
    sda_q <= 1'b0;
    w(20);
    hi();
    sda_q <= 1'b1;
    w(20);
  endtask : stop
  // Sends a byte and returns the acknowledge.
  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    logic lost;
    lost = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      bt(d[i] | lost, s);
      // A master that sends high but sees low has lost and lets SDA go.
      if (d[i] && !s) lost = 1'b1;
    end
    bt(1'b1, s);
    ack = ~s;
  endtask : wr
  // Pulses SCL high for two clocks, shorter than the line filter accepts.
  task automatic spike;
    w(5);
    scl_q <= 1'b1;
    w(2);
    scl_q <= 1'b0;
  endtask : spike
  // Reads a byte and answers it.
  task automatic rd(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bt(1'b1, s);
      d[i] = s;
    end
    bt(~ack, s);
  endtask : rd
endmodule : tsi2c_master

/* test/tsi2c_port_monitor.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Port checker on the top ports.
// ----------------------------------------
module tsi2c_port_monitor (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic link_clk_in,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_out,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic [7:0] reg_addr_out,
  input wire logic [7:0] reg_wdata_out,
  input wire logic reg_we_out,
  input wire logic reg_re_out,
  input wire logic [7:0] reg_rdata_in,
  input wire logic reg_busy_in,
  input wire logic bus_busy_out
);
  property p_sda_low;
    @(posedge link_clk_in) disable iff (!rstn_in) $changed(sda_oe_out) |-> !scl_in;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("SDA moved, SCL high");
  property p_str_low;
    @(posedge link_clk_in) disable iff (!rstn_in) $rose(scl_oe_out) |-> !$past(scl_in);
  endproperty
  a_str_low: assert property (p_str_low) else $error("stretch began high");
  property p_str_end;
    @(posedge link_clk_in) disable iff (!rstn_in) $rose(scl_oe_out) |-> ##[1:300] !scl_oe_out;
  endproperty
  a_str_end: assert property (p_str_end) else $error("stretch too long");
  property p_od;
    @(posedge link_clk_in) disable iff (!rstn_in) !scl_out && !sda_out;
  endproperty
  a_od: assert property (p_od) else $error("line driven high");
  property p_idle;
    @(posedge core_clk_in) disable iff (!rstn_in) !bus_busy_out |-> !sda_oe_out && !scl_oe_out;
  endproperty
  a_idle: assert property (p_idle) else $error("drive while idle");
  property p_we;
    @(posedge core_clk_in) disable iff (!rstn_in) reg_we_out |=> !reg_we_out;
  endproperty
  a_we: assert property (p_we) else $error("write strobe long");
  property p_re;
    @(posedge core_clk_in) disable iff (!rstn_in) reg_re_out |=> !reg_re_out;
  endproperty
  a_re: assert property (p_re) else $error("read strobe long");
  property p_both;
    @(posedge core_clk_in) disable iff (!rstn_in) reg_we_out |-> !reg_re_out;
  endproperty
  a_both: assert property (p_both) else $error("both strobes");
  property p_frame;
    @(posedge core_clk_in) disable iff (!rstn_in) reg_we_out || reg_re_out |-> bus_busy_out;
  endproperty
  a_frame: assert property (p_frame) else $error("strobe outside frame");
  property p_bsy;
    @(posedge core_clk_in) disable iff (!rstn_in) reg_busy_in |-> !reg_we_out && !reg_re_out;
  endproperty
  a_bsy: assert property (p_bsy) else $error("access while bank busy");
endmodule : tsi2c_port_monitor

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
  import tsi2c_pkg::*;
  logic core_clk_in = 1'b0; // Core clock.
  logic link_clk_in = 1'b0; // Link sampling clock.
  logic rstn_in = 1'b0; // Reset, active low.
  logic reg_busy_in = 1'b0; // Bank cannot serve.
  logic scl_w, sda_w, scl_oe, sda_oe, we, re, bus_busy;
  logic [7:0] addr, wdata, rdata, d;
  logic [7:0] mem [0:255]; // Register bank model.
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  // ----------------------------------------
  // Clocks, bank model and timeout.
  // ----------------------------------------
  initial forever #5 core_clk_in = ~core_clk_in;
  initial begin
    #1.3;
    forever #3 link_clk_in = ~link_clk_in;
  end
  initial for (int i = 0; i < 256; i++) mem[i] = ~8'(i);
  assign rdata = mem[addr];
  // The bank stores on the write strobe.
  always @(posedge core_clk_in) begin
    if (we) mem[addr] <= wdata;
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      wrap_up();
    end
  end
  tsi2c_port dut_u (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .link_clk_in(link_clk_in),
    .scl_in(scl_w), .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(),
    .sda_oe_out(sda_oe), .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_we_out(we),
    .reg_re_out(re), .reg_rdata_in(rdata), .reg_busy_in(reg_busy_in), .bus_busy_out(bus_busy));
  tsi2c_master m_u (.clk_in(core_clk_in), .scl_oe_in(scl_oe), .sda_oe_in(sda_oe),
    .scl_out(scl_w), .sda_out(sda_w));
  // ----------------------------------------
  // Checking and closing.
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  // Sends a byte and compares the acknowledge.
  task automatic wb(input logic [7:0] v, input logic exp);
    logic a;
    m_u.wr(v, a);
    chk({7'h00, a}, {7'h00, exp});
  endtask : wb
  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic t_write;
    m_u.start();
    m_u.spike();
    chk({7'h00, bus_busy}, 8'h01);
    wb(TSI2C_DEV_ADDR, 1'b1);
    wb(8'h02, 1'b1);
    wb(8'h33, 1'b1);
    wb(8'h22, 1'b1);
    m_u.stop();
    chk({7'h00, bus_busy}, 8'h00);
    chk(mem[2], 8'h33);
    chk(mem[3], 8'h22);
  endtask : t_write
  task automatic t_read;
    m_u.start();
    wb(TSI2C_DEV_ADDR, 1'b1);
    wb(8'h02, 1'b1);
    m_u.stop();
    m_u.start();
    wb({TSI2C_DEV_ADDR[7:1], TSI2C_DIR_READ}, 1'b1);
    m_u.rd(1'b1, d);
    chk(d, 8'h33);
    m_u.rd(1'b0, d);
    chk(d, 8'h22);
    m_u.stop();
  endtask : t_read
  task automatic t_refuse;
    m_u.start();
    wb(8'hE0, 1'b0);
    m_u.stop();
    reg_busy_in <= 1'b1;
    m_u.start();
    wb(TSI2C_DEV_ADDR, 1'b0);
    m_u.stop();
    reg_busy_in <= 1'b0;
    m_u.start();
    wb(TSI2C_DEV_ADDR, 1'b1);
    wb(8'h40, 1'b1);
    reg_busy_in <= 1'b1;
    wb(8'h77, 1'b0);
    m_u.stop();
    reg_busy_in <= 1'b0;
    chk(mem[8'h40], 8'hBF);
  endtask : t_refuse
  task automatic t_rstart;
    m_u.start();
    wb(TSI2C_DEV_ADDR, 1'b1);
    wb(8'h10, 1'b1);
    wb(8'h5A, 1'b1);
    m_u.start();
    chk({7'h00, bus_busy}, 8'h01);
    wb(TSI2C_DEV_ADDR, 1'b1);
    wb(8'h11, 1'b1);
    wb(8'hA5, 1'b1);
    m_u.start();
    wb({TSI2C_DEV_ADDR[7:1], TSI2C_DIR_READ}, 1'b1);
    m_u.rd(1'b0, d);
    chk(d, 8'hED);
    m_u.stop();
    chk(mem[8'h10], 8'h5A);
    chk(mem[8'h11], 8'hA5);
  endtask : t_rstart
  // Main sequence.
  initial begin
    repeat (10) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    repeat (20) @(posedge core_clk_in);
    t_write();
    t_read();
    t_refuse();
    t_rstart();
    wrap_up();
  end
endmodule : tb
bind tsi2c_port tsi2c_port_monitor mon_u (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
  .link_clk_in(link_clk_in), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .reg_addr_out(reg_addr_out),
  .reg_wdata_out(reg_wdata_out), .reg_we_out(reg_we_out), .reg_re_out(reg_re_out),
  .reg_rdata_in(reg_rdata_in), .reg_busy_in(reg_busy_in), .bus_busy_out(bus_busy_out));
